// ==== hdl/ufc_core.sv ====
// Purpose: Software flow control, special character, timeout and interrupt logic
// Assumes: Receiver and transmitter shifters sit outside on the same clock
// Notes:   Receive FIFO is the ufc_fifo module below
`timescale 1ns/10ps

// Synchronous FIFO with valid and ready on both sides
module ufc_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// Clock and reset
	input  wire logic                 sys_clk_in,
	input  wire logic                 resetn_in,
	// Fill side
	input  wire logic                 in_valid_in,
	input  wire logic [W-1:0]         in_data_in,
	output logic                      in_ready_out,
	// Drain side
	output logic                      out_valid_out,
	output logic [W-1:0]              out_data_out,
	input  wire logic                 out_ready_in,
	// Fill level
	output logic [$clog2(D):0]        count_out
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0]   cnt_reg;
	logic          push;
	logic          pop;

	// Handshakes
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;
	assign in_ready_out  = (cnt_reg != (AW+1)'(D));
	assign out_valid_out = (cnt_reg != '0);
	assign out_data_out  = mem[rp_reg];
	assign count_out     = cnt_reg;

	// Storage
	always_ff @(posedge sys_clk_in) begin
		if (push)
			mem[wp_reg] <= in_data_in;
	end

	// Pointers and count
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push)
				wp_reg <= wp_reg + 1'b1;
			if (pop)
				rp_reg <= rp_reg + 1'b1;
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // ufc_fifo

// Notes on behaviour
// - Xoff match stops transmit after current character
// - Xoff match sets flag and interrupt if enabled
// - Xon match resumes transmit, clears flags
// - Xon-any mode: any character but a matched Xoff resumes transmit
// - Reset zeroes the four flow character registers
// - Double mode matches two consecutive characters
// - Matched Xoff, and Xon while suspended, never enter receive FIFO
// - FIFO above trigger sends Xoff automatically
// - FIFO below trigger after Xoff sends Xon
// - Special character: store, flag status bit four
// - Compare only the programmed word length bits
// - Zero divisor reads back identification and revision
// - Flow and handshake interrupts enabled by bits 5-7
// - Transmit empty interrupt pending after reset
// - Report only highest pending; handshake lowest
// - Data ready and timeout share one level
// - No timeout while receive FIFO empty
// - Timeout restarts at stop bit and data read
// - Timeout length is four words plus twelve
// - Select pin high keeps interrupt output enabled
// - Divisor bytes reachable only with latch bit set
// - Enhanced registers reachable only with special value
module ufc_core #(
	parameter int         DEPTH   = 16,
	parameter logic [7:0] DEV_ID  = 8'hA5, // Arbitrary identification value
	parameter logic [7:0] DEV_REV = 8'h01  // Arbitrary revision value
) (
	// Clock and reset
	input  wire logic                  sys_clk_in,
	input  wire logic                  resetn_in,
	// Host access
	input  wire ufc_pkg::ufc_host_t    host_in,
	output logic [7:0]                 rdata_out,
	// Receiver side
	input  wire ufc_pkg::ufc_rx_t      rx_in,
	input  wire logic                  bit_tick_in,
	input  wire logic [4:0]            rx_trig_in,
	// Transmitter side
	output logic                       tx_valid_out,
	output logic [7:0]                 tx_char_out,
	input  wire logic                  tx_ready_in,
	// Handshake line events and interrupt select pin
	input  wire logic [1:0]            hs_event_in,
	input  wire logic                  interrupt_select_pin_in,
	// Interrupt and status
	output logic                       int_out,
	output logic                       int_oe_n_out,
	output logic                       tx_suspended_out
);
	logic [7:0] lcr_reg, ier_reg, mcr_reg, efr_reg, dll_reg, dlm_reg;
	logic [7:0] xon1_reg, xon2_reg, xoff1_reg, xoff2_reg;
	logic [7:0] thr_reg, held_reg, mask, cand;
	logic       thr_full_reg, susp_reg, held_is_off_reg, held_is_on_reg, held_v_reg, replay_reg;
	logic       sent_off_reg, thr_int_reg, xoff_int_reg, hs_int_reg, to_int_reg, ovr_reg;
	logic       sel_s1_reg, sel_s2_reg, cand_v, enh, dlab, wr_hit, rd_hit, isr_rd, rhr_rd;
	logic       m_off1, m_off2, m_on1, m_on2, dbl, act_off, act_on, push_held, push_cand, slot;
	logic [7:0] first_off, first_on, isr_code, fifo_d, push_d;
	logic       fifo_rdy, fifo_v, push;
	logic [5:0] to_cnt_reg, to_lim;
	logic [$clog2(DEPTH):0] cnt;
	ufc_pkg::ufc_txs_t ts_reg;

	// Bank decode
	assign enh    = (lcr_reg == ufc_pkg::LCR_ENH);
	assign dlab   = lcr_reg[ufc_pkg::LCR_DLAB] && !enh;
	assign wr_hit = host_in.wr;
	assign rd_hit = host_in.rd;
	assign isr_rd = rd_hit && !dlab && !enh && (host_in.addr == ufc_pkg::A_ISR);
	assign rhr_rd = rd_hit && !dlab && !enh && (host_in.addr == ufc_pkg::A_DATA);

	// Word length mask, bit 0 is the first received bit
	always_comb begin
		case (lcr_reg[1:0])
			2'h0:    mask = 8'h1F;
			2'h1:    mask = 8'h3F;
			2'h2:    mask = 8'h7F;
			default: mask = 8'hFF;
		endcase
	end

	// Candidate character: fresh input or a replayed held one
	assign cand_v    = rx_in.valid || replay_reg;
	assign cand      = replay_reg ? held_reg : rx_in.data;
	assign dbl       = (efr_reg[1:0] == ufc_pkg::FM_DBL);
	assign first_off = (efr_reg[1:0] == ufc_pkg::FM_CHR2) ? xoff2_reg : xoff1_reg;
	assign first_on  = (efr_reg[1:0] == ufc_pkg::FM_CHR2) ? xon2_reg : xon1_reg;
	assign m_off1    = ((cand ^ first_off) & mask) == 8'h00;
	assign m_on1     = ((cand ^ first_on) & mask) == 8'h00;
	assign m_off2    = ((cand ^ xoff2_reg) & mask) == 8'h00;
	assign m_on2     = ((cand ^ xon2_reg) & mask) == 8'h00;

	// Match decisions; double mode completes on the second character
	always_comb begin
		act_off   = 1'b0;
		act_on    = 1'b0;
		push_held = 1'b0;
		push_cand = 1'b0;
		if (cand_v && !replay_reg && held_v_reg) begin
			act_off   = held_is_off_reg && m_off2;
			act_on    = held_is_on_reg && m_on2 && susp_reg;
			push_held = !(act_off || act_on);
		end else if (cand_v && efr_reg[1:0] != ufc_pkg::FM_OFF && !dbl) begin
			act_off   = m_off1;
			act_on    = m_on1 && susp_reg && !m_off1;
			push_cand = !(act_off || act_on);
		end else if (cand_v && !dbl) begin
			push_cand = 1'b1;
		end else if (cand_v && !(m_off1 || (m_on1 && susp_reg))) begin
			push_cand = 1'b1;
		end
	end

	// Held first character in double mode
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			held_v_reg      <= 1'b0;
			held_reg        <= ufc_pkg::RST_BYTE;
			held_is_off_reg <= 1'b0;
			held_is_on_reg  <= 1'b0;
			replay_reg      <= 1'b0;
		end else begin
			// Unpaired held char is stored now, the new one is replayed next cycle
			replay_reg <= push_held;
			if (cand_v && dbl && !(held_v_reg && !replay_reg)) begin
				held_v_reg      <= m_off1 || (m_on1 && susp_reg);
				held_reg        <= cand;
				held_is_off_reg <= m_off1;
				held_is_on_reg  <= m_on1 && susp_reg;
			end else if (cand_v && held_v_reg) begin
				held_v_reg <= 1'b0;
				held_reg   <= cand;
				held_is_off_reg <= m_off1;
				held_is_on_reg  <= m_on1 && susp_reg;
			end
		end
	end

	// Receive FIFO fill; matched Xoff and, while suspended, matched Xon characters are dropped
	assign push   = push_held || push_cand;
	assign push_d = push_held ? held_reg : cand;
	ufc_fifo #(.W(8), .D(DEPTH)) u_rxf (
		.sys_clk_in    (sys_clk_in),
		.resetn_in     (resetn_in),
		.in_valid_in   (push),
		.in_data_in    (push_d),
		.in_ready_out  (fifo_rdy),
		.out_valid_out (fifo_v),
		.out_data_out  (fifo_d),
		.out_ready_in  (rhr_rd),
		.count_out     (cnt)
	);

	// Suspension state
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			susp_reg <= 1'b0;
		else if (act_off)
			susp_reg <= 1'b1;
		else if (act_on || (susp_reg && cand_v && mcr_reg[ufc_pkg::MCR_XANY]))
			susp_reg <= 1'b0;
	end

	// Register writes, all but LCR gated by the selected bank
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			lcr_reg   <= ufc_pkg::RST_BYTE;
			ier_reg   <= ufc_pkg::RST_BYTE;
			mcr_reg   <= ufc_pkg::RST_BYTE;
			efr_reg   <= ufc_pkg::RST_BYTE;
			dll_reg   <= ufc_pkg::RST_BYTE;
			dlm_reg   <= ufc_pkg::RST_BYTE;
			xon1_reg  <= ufc_pkg::RST_BYTE;
			xon2_reg  <= ufc_pkg::RST_BYTE;
			xoff1_reg <= ufc_pkg::RST_BYTE;
			xoff2_reg <= ufc_pkg::RST_BYTE;
		end else if (wr_hit) begin
			if (host_in.addr == ufc_pkg::A_LCR)
				lcr_reg <= host_in.wdata;
			else if (enh) begin
				case (host_in.addr)
					ufc_pkg::A_EFR:   efr_reg   <= host_in.wdata;
					ufc_pkg::A_XON1:  xon1_reg  <= host_in.wdata;
					ufc_pkg::A_XON2:  xon2_reg  <= host_in.wdata;
					ufc_pkg::A_XOFF1: xoff1_reg <= host_in.wdata;
					ufc_pkg::A_XOFF2: xoff2_reg <= host_in.wdata;
					default: ;
				endcase
			end else if (dlab && host_in.addr == ufc_pkg::A_DLL)
				dll_reg <= host_in.wdata;
			else if (dlab && host_in.addr == ufc_pkg::A_DLM)
				dlm_reg <= host_in.wdata;
			else if (!dlab && host_in.addr == ufc_pkg::A_IER)
				ier_reg <= host_in.wdata;
			else if (host_in.addr == ufc_pkg::A_MCR)
				mcr_reg <= host_in.wdata;
		end
	end

	// Host transmit holding register
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			thr_full_reg <= 1'b0;
			thr_reg      <= ufc_pkg::RST_BYTE;
		end else if (wr_hit && !dlab && !enh && host_in.addr == ufc_pkg::A_DATA) begin
			thr_full_reg <= 1'b1;
			thr_reg      <= host_in.wdata;
		end else if (slot && ts_reg == ufc_pkg::TS_IDLE && thr_full_reg && !susp_reg) begin
			thr_full_reg <= 1'b0;
		end
	end

	// Automatic Xoff/Xon sequencer, inserted between whole characters
	assign slot = !tx_valid_out || tx_ready_in;
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ts_reg       <= ufc_pkg::TS_IDLE;
			sent_off_reg <= 1'b0;
			tx_valid_out <= 1'b0;
			tx_char_out  <= ufc_pkg::RST_BYTE;
		end else begin
			if (tx_valid_out && tx_ready_in)
				tx_valid_out <= 1'b0;
			case (ts_reg)
				ufc_pkg::TS_IDLE: begin
					if (efr_reg[3:2] != ufc_pkg::FM_OFF && !sent_off_reg && cnt > rx_trig_in) begin
						ts_reg       <= ufc_pkg::TS_OFF1;
						sent_off_reg <= 1'b1;
					end else if (sent_off_reg && cnt < rx_trig_in) begin
						ts_reg       <= ufc_pkg::TS_ON1;
						sent_off_reg <= 1'b0;
					end else if (slot && thr_full_reg && !susp_reg) begin
						tx_valid_out <= 1'b1;
						tx_char_out  <= thr_reg;
					end
				end
				ufc_pkg::TS_OFF1: if (slot) begin
					tx_valid_out <= 1'b1;
					tx_char_out  <= (efr_reg[3:2] == ufc_pkg::FM_CHR2) ? xoff2_reg : xoff1_reg;
					ts_reg       <= (efr_reg[3:2] == ufc_pkg::FM_DBL) ? ufc_pkg::TS_OFF2 : ufc_pkg::TS_IDLE;
				end
				ufc_pkg::TS_OFF2: if (slot) begin
					tx_valid_out <= 1'b1;
					tx_char_out  <= xoff2_reg;
					ts_reg       <= ufc_pkg::TS_IDLE;
				end
				ufc_pkg::TS_ON1: if (slot) begin
					tx_valid_out <= 1'b1;
					tx_char_out  <= (efr_reg[3:2] == ufc_pkg::FM_CHR2) ? xon2_reg : xon1_reg;
					ts_reg       <= (efr_reg[3:2] == ufc_pkg::FM_DBL) ? ufc_pkg::TS_ON2 : ufc_pkg::TS_IDLE;
				end
				ufc_pkg::TS_ON2: if (slot) begin
					tx_valid_out <= 1'b1;
					tx_char_out  <= xon2_reg;
					ts_reg       <= ufc_pkg::TS_IDLE;
				end
				default: ts_reg <= ufc_pkg::TS_IDLE;
			endcase
		end
	end

	// Receive timeout counter in bit times
	assign to_lim = 6'(ufc_pkg::TO_MULT * (ufc_pkg::WL_MIN + 6'(lcr_reg[1:0])) + ufc_pkg::TO_BASE);
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			to_cnt_reg <= '0;
			to_int_reg <= 1'b0;
		end else begin
			if (rx_in.stop_mid || rhr_rd || !fifo_v)
				to_cnt_reg <= '0;
			else if (bit_tick_in && to_cnt_reg != to_lim)
				to_cnt_reg <= to_cnt_reg + 6'h01;
			if (fifo_v && bit_tick_in && to_cnt_reg == to_lim - 6'h01)
				to_int_reg <= 1'b1;
			else if (rhr_rd || !fifo_v)
				to_int_reg <= 1'b0;
		end
	end

	// Sticky interrupt sources; a set in the clearing cycle wins
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			thr_int_reg  <= 1'b1;
			xoff_int_reg <= 1'b0;
			hs_int_reg   <= 1'b0;
			ovr_reg      <= 1'b0;
		end else begin
			if (thr_full_reg && slot && ts_reg == ufc_pkg::TS_IDLE && !susp_reg)
				thr_int_reg <= 1'b1;
			else if ((isr_rd && isr_code == ufc_pkg::IS_THR) || (wr_hit && host_in.addr == ufc_pkg::A_DATA && !dlab && !enh))
				thr_int_reg <= 1'b0;
			if ((act_off && ier_reg[ufc_pkg::IER_XOFF]) || (cand_v && efr_reg[ufc_pkg::EFR_SPEC] && m_off2))
				xoff_int_reg <= 1'b1;
			else if ((isr_rd && isr_code == ufc_pkg::IS_XOFF) || act_on)
				xoff_int_reg <= 1'b0;
			if (|hs_event_in)
				hs_int_reg <= 1'b1;
			else if (isr_rd && isr_code == ufc_pkg::IS_HS)
				hs_int_reg <= 1'b0;
			if (push && !fifo_rdy)
				ovr_reg <= 1'b1;
			else if (rd_hit && !dlab && !enh && host_in.addr == ufc_pkg::A_LSR)
				ovr_reg <= 1'b0;
		end
	end

	// Highest pending source only
	always_comb begin
		if (ier_reg[ufc_pkg::IER_RX] && to_int_reg)
			isr_code = ufc_pkg::IS_RXTO;
		else if (ier_reg[ufc_pkg::IER_RX] && cnt >= rx_trig_in && fifo_v)
			isr_code = ufc_pkg::IS_RXD;
		else if (ier_reg[ufc_pkg::IER_THR] && thr_int_reg)
			isr_code = ufc_pkg::IS_THR;
		else if (ier_reg[ufc_pkg::IER_XOFF] && xoff_int_reg)
			isr_code = ufc_pkg::IS_XOFF;
		else if ((ier_reg[ufc_pkg::IER_HS0] || ier_reg[ufc_pkg::IER_HS1]) && hs_int_reg)
			isr_code = ufc_pkg::IS_HS;
		else
			isr_code = ufc_pkg::IS_NONE;
	end

	// Interrupt select pin synchroniser
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sel_s1_reg <= 1'b0;
			sel_s2_reg <= 1'b0;
		end else begin
			sel_s1_reg <= interrupt_select_pin_in;
			sel_s2_reg <= sel_s1_reg;
		end
	end

	// Interrupt output and its three-state enable
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			int_out          <= 1'b0;
			int_oe_n_out     <= 1'b1;
			tx_suspended_out <= 1'b0;
		end else begin
			int_out          <= (isr_code != ufc_pkg::IS_NONE);
			int_oe_n_out     <= !(sel_s2_reg || mcr_reg[ufc_pkg::MCR_INTEN]);
			tx_suspended_out <= susp_reg;
		end
	end

	// Registered read data
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			rdata_out <= ufc_pkg::RST_BYTE;
		else if (rd_hit) begin
			if (enh) begin
				case (host_in.addr)
					ufc_pkg::A_EFR:   rdata_out <= efr_reg;
					ufc_pkg::A_XON1:  rdata_out <= xon1_reg;
					ufc_pkg::A_XON2:  rdata_out <= xon2_reg;
					ufc_pkg::A_XOFF1: rdata_out <= xoff1_reg;
					ufc_pkg::A_XOFF2: rdata_out <= xoff2_reg;
					default:          rdata_out <= ufc_pkg::RST_BYTE;
				endcase
			end else if (dlab && host_in.addr == ufc_pkg::A_DLL)
				rdata_out <= (dll_reg == 8'h00 && dlm_reg == 8'h00) ? DEV_REV : dll_reg;
			else if (dlab && host_in.addr == ufc_pkg::A_DLM)
				rdata_out <= (dll_reg == 8'h00 && dlm_reg == 8'h00) ? DEV_ID : dlm_reg;
			else begin
				case (host_in.addr)
					ufc_pkg::A_DATA: rdata_out <= fifo_v ? fifo_d : ufc_pkg::RST_BYTE;
					ufc_pkg::A_IER:  rdata_out <= ier_reg;
					ufc_pkg::A_ISR:  rdata_out <= isr_code;
					ufc_pkg::A_LCR:  rdata_out <= lcr_reg;
					ufc_pkg::A_MCR:  rdata_out <= mcr_reg;
					ufc_pkg::A_LSR:  rdata_out <= {1'b0, !thr_full_reg && !tx_valid_out, !thr_full_reg,
						3'h0, ovr_reg, fifo_v};
					default:         rdata_out <= ufc_pkg::RST_BYTE;
				endcase
			end
		end
	end
endmodule // ufc_core

// ==== hdl/ufc_pkg.sv ====
// Purpose: Shared constants and types for the flow-control and interrupt block
// Assumes: One receive channel, host access through a simple strobe port
// Notes:   Register indexes are the three address lines of the host port
package ufc_pkg;
	// Register indexes per bank
	localparam logic [2:0] A_DATA    = 3'h0;
	localparam logic [2:0] A_IER     = 3'h1;
	localparam logic [2:0] A_ISR     = 3'h2;
	localparam logic [2:0] A_LCR     = 3'h3;
	localparam logic [2:0] A_MCR     = 3'h4;
	localparam logic [2:0] A_LSR     = 3'h5;
	localparam logic [2:0] A_DLL     = 3'h0;
	localparam logic [2:0] A_DLM     = 3'h1;
	localparam logic [2:0] A_EFR     = 3'h2;
	localparam logic [2:0] A_XON1    = 3'h4;
	localparam logic [2:0] A_XON2    = 3'h5;
	localparam logic [2:0] A_XOFF1   = 3'h6;
	localparam logic [2:0] A_XOFF2   = 3'h7;
	// Bank selection values
	localparam logic [7:0] LCR_ENH   = 8'hBF;
	localparam int         LCR_DLAB  = 7;
	// Field positions
	localparam int         IER_THR   = 1;
	localparam int         IER_RX    = 3;
	localparam int         IER_XOFF  = 5;
	localparam int         IER_HS0   = 6;
	localparam int         IER_HS1   = 7;
	localparam int         MCR_INTEN = 3;
	localparam int         MCR_XANY  = 5;
	localparam int         EFR_SPEC  = 5;
	// Flow modes in enhanced-feature bits 1:0 (receive) and 3:2 (auto send)
	localparam logic [1:0] FM_OFF    = 2'h0;
	localparam logic [1:0] FM_CHR2   = 2'h1;
	localparam logic [1:0] FM_DBL    = 2'h3;
	// Interrupt status codes
	localparam logic [7:0] IS_NONE   = 8'h01;
	localparam logic [7:0] IS_THR    = 8'h02;
	localparam logic [7:0] IS_RXD    = 8'h04;
	localparam logic [7:0] IS_RXTO   = 8'h0C;
	localparam logic [7:0] IS_XOFF   = 8'h10;
	localparam logic [7:0] IS_HS     = 8'h20;
	// Timeout in bit times is TO_MULT * word length + TO_BASE
	localparam logic [5:0] TO_MULT   = 6'h04;
	localparam logic [5:0] TO_BASE   = 6'h0C;
	localparam logic [5:0] WL_MIN    = 6'h05;
	localparam logic [7:0] RST_BYTE  = 8'h00;
	// Transmit sequencer states
	typedef enum logic [4:0] {
		TS_IDLE = 5'h01,
		TS_OFF1 = 5'h02,
		TS_OFF2 = 5'h04,
		TS_ON1  = 5'h08,
		TS_ON2  = 5'h10
	} ufc_txs_t;
	// Received character from the deserialiser
	typedef struct packed {
		logic       valid;
		logic       stop_mid;
		logic [7:0] data;
	} ufc_rx_t;
	// Host register access strobes
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} ufc_host_t;
endpackage

// ==== dv/ufc_tx_sink.sv ====
// Purpose: Far-side transmitter model that takes offered characters
// Assumes: Valid and ready handshake on the rising edge
// Notes:   Slow mode accepts every other cycle to stall the sequencer
`timescale 1ns/10ps
module ufc_tx_sink (
	// Clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       resetn_in,
	// Control
	input  wire logic       slow_in,
	// Character stream
	input  wire logic       tx_valid_in,
	input  wire logic [7:0] tx_char_in,
	output logic            tx_ready_out,
	// Log of taken characters
	output logic [3:0]      n_seen_out,
	output logic [7:0]      last_out
);
	// Ready pattern and capture of each taken character
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tx_ready_out <= 1'b0;
			n_seen_out   <= 4'h0;
			last_out     <= 8'h00;
		end else begin
			tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
			if (tx_valid_in && tx_ready_out) begin
				n_seen_out <= n_seen_out + 4'h1;
				last_out   <= tx_char_in;
			end
		end
	end
endmodule // ufc_tx_sink

// ==== dv/ufc_core_chk.sv ====
// Purpose: Port-level checker for the flow-control core
// Assumes: Single clock domain, async active-low reset
// Notes:   Attached by bind below
`timescale 1ns/10ps
module ufc_core_chk (
	// Clock and reset
	input wire logic              sys_clk_in,
	input wire logic              resetn_in,
	// Watched ports
	input wire ufc_pkg::ufc_host_t host_in,
	input wire logic [7:0]        rdata_out,
	input wire ufc_pkg::ufc_rx_t  rx_in,
	input wire logic              tx_valid_out,
	input wire logic [7:0]        tx_char_out,
	input wire logic              tx_ready_in,
	input wire logic              interrupt_select_pin_in,
	input wire logic              int_out,
	input wire logic              int_oe_n_out,
	input wire logic              tx_suspended_out
);
	logic wrote_reg;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	// Remembers any host write since reset
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) wrote_reg <= 1'b0;
		else if (host_in.wr) wrote_reg <= 1'b1;
	end
	chk_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_char_out))
		else $error("offered char changed before taken");
	chk_tx_drop: assert property ($fell(tx_valid_out) |-> $past(tx_ready_in))
		else $error("offer withdrawn without acceptance");
	chk_sel_oe: assert property (interrupt_select_pin_in [*4] |=> !int_oe_n_out)
		else $error("interrupt pin not driven with select high");
	chk_oe_cause: assert property (!int_oe_n_out |-> wrote_reg || $past(interrupt_select_pin_in, 2)
		|| $past(interrupt_select_pin_in, 3) || $past(interrupt_select_pin_in, 4))
		else $error("interrupt pin driven without cause");
	chk_susp_rise: assert property ($rose(tx_suspended_out) |-> $past(rx_in.valid) || $past(rx_in.valid, 2))
		else $error("suspend without received char");
	chk_susp_fall: assert property ($fell(tx_suspended_out) |-> $past(rx_in.valid) || $past(rx_in.valid, 2))
		else $error("resume without received char");
	chk_rd_stand: assert property (!$past(host_in.rd) |-> $stable(rdata_out))
		else $error("read data changed without read");
	chk_int_cause: assert property (int_out |-> wrote_reg)
		else $error("interrupt before any enable write");
endmodule // ufc_core_chk

bind ufc_core ufc_core_chk i_chk (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .host_in(host_in),
	.rdata_out(rdata_out), .rx_in(rx_in), .tx_valid_out(tx_valid_out), .tx_char_out(tx_char_out),
	.tx_ready_in(tx_ready_in), .interrupt_select_pin_in(interrupt_select_pin_in), .int_out(int_out),
	.int_oe_n_out(int_oe_n_out), .tx_suspended_out(tx_suspended_out));

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench for the flow-control core
// Assumes: Host strobes and received chars driven on the rising edge
// Notes:   Reset, transmit interrupt and reset-value reads first, then register rows, then hand-written flow and timeout cases
`timescale 1ns/10ps
module testbench;
	logic               clk = 1'b0;
	logic               rstn = 1'b0;
	ufc_pkg::ufc_host_t h = '0;
	ufc_pkg::ufc_rx_t   r = '0;
	logic               bt = 1'b0;
	logic [4:0]         trig = 5'h02;
	logic               sel = 1'b0;
	logic               slow = 1'b0;
	logic [1:0]         hs = 2'h0;
	logic               tv, rdy, io, ioe, sus;
	logic [7:0]         rdat, tc, last;
	logic [3:0]         seen;
	int                 fails = 0;
	int                 n_compared = 0;
	logic [7:0]         rows [8][4] = '{'{8'hBF, 8'h04, 8'h5A, 8'h5A}, '{8'hBF, 8'h05, 8'hC3, 8'hC3},
		'{8'hBF, 8'h06, 8'h13, 8'h13}, '{8'hBF, 8'h07, 8'h93, 8'h93}, '{8'h80, 8'h00, 8'h12, 8'h12},
		'{8'h80, 8'h01, 8'h34, 8'h34}, '{8'h80, 8'h07, 8'h55, 8'h00}, '{8'h03, 8'h07, 8'h77, 8'h00}};
	// Clock
	initial begin
		forever #20 clk = ~clk;
	end
	ufc_core #(.DEPTH(16), .DEV_ID(8'h3C), .DEV_REV(8'h07)) i_dut (.sys_clk_in(clk), .resetn_in(rstn),
		.host_in(h), .rdata_out(rdat), .rx_in(r), .bit_tick_in(bt), .rx_trig_in(trig), .tx_valid_out(tv),
		.tx_char_out(tc), .tx_ready_in(rdy), .hs_event_in(hs), .interrupt_select_pin_in(sel),
		.int_out(io), .int_oe_n_out(ioe), .tx_suspended_out(sus));
	ufc_tx_sink i_sink (.sys_clk_in(clk), .resetn_in(rstn), .slow_in(slow), .tx_valid_in(tv),
		.tx_char_in(tc), .tx_ready_out(rdy), .n_seen_out(seen), .last_out(last));
	task give_verdict;
		$display("compared %0d, fails %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk) h <= '{1'b1, 1'b0, a, d};
		@(posedge clk) h <= '0;
	endtask
	task rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk) h <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk) h <= '0;
		#1 chk(rdat, e);
	endtask
	task rx(input logic [7:0] d);
		@(posedge clk) r <= '{1'b1, 1'b1, d};
		@(posedge clk) r <= '0;
		repeat (2) @(posedge clk);
	endtask
	task tick(input int n);
		repeat (n) begin
			@(posedge clk) bt <= 1'b1;
			@(posedge clk) bt <= 1'b0;
		end
	endtask
	task wait_seen(input logic [3:0] n);
		for (int i = 0; i < 100 && seen !== n; i++) @(posedge clk);
		if (seen !== n) begin
			fails++;
			$display("mismatch at %0t: sink count stuck", $time);
			give_verdict;
		end
	endtask
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		#1 chk({tv, io, ioe, sus}, 8'h02);
		@(posedge clk) rstn <= 1'b1;
		wr(ufc_pkg::A_IER, 8'h02);
		rd(ufc_pkg::A_ISR, ufc_pkg::IS_THR);
		wr(ufc_pkg::A_IER, 8'h00);
		wr(ufc_pkg::A_LCR, 8'hBF);
		for (int a = 4; a < 8; a++) rd(a[2:0], 8'h00);
		// Register rows
		for (int i = 0; i < 8; i++) begin
			wr(ufc_pkg::A_LCR, rows[i][0]);
			wr(rows[i][1][2:0], rows[i][2]);
			rd(rows[i][1][2:0], rows[i][3]);
		end
		wr(ufc_pkg::A_LCR, 8'h80);
		wr(ufc_pkg::A_DLL, 8'h00);
		wr(ufc_pkg::A_DLM, 8'h00);
		rd(ufc_pkg::A_DLM, 8'h3C);
		rd(ufc_pkg::A_DLL, 8'h07);
		// Single-char suspend and resume, flow chars not stored
		wr(ufc_pkg::A_LCR, 8'hBF);
		wr(ufc_pkg::A_XOFF1, 8'h13);
		wr(ufc_pkg::A_XON1, 8'h11);
		wr(ufc_pkg::A_EFR, 8'h02);
		wr(ufc_pkg::A_LCR, 8'h03);
		wr(ufc_pkg::A_IER, 8'h08);
		rx(8'h13);
		chk(sus, 1'b1);
		rd(ufc_pkg::A_ISR, ufc_pkg::IS_NONE);
		rx(8'h41);
		rx(8'h42);
		rd(ufc_pkg::A_ISR, ufc_pkg::IS_RXD);
		rx(8'h11);
		chk(sus, 1'b0);
		rd(ufc_pkg::A_DATA, 8'h41);
		rd(ufc_pkg::A_DATA, 8'h42);
		// Any character resumes
		wr(ufc_pkg::A_MCR, 8'h20);
		rx(8'h13);
		rx(8'h55);
		chk(sus, 1'b0);
		rd(ufc_pkg::A_DATA, 8'h55);
		wr(ufc_pkg::A_MCR, 8'h00);
		// Five-bit words compare only the low bits
		wr(ufc_pkg::A_LCR, 8'h00);
		wr(ufc_pkg::A_IER, 8'h20);
		rx(8'h33);
		chk(sus, 1'b1);
		rd(ufc_pkg::A_ISR, ufc_pkg::IS_XOFF);
		rx(8'hF1);
		chk(sus, 1'b0);
		// Automatic Xoff and Xon around the trigger, sink stalling
		wr(ufc_pkg::A_LCR, 8'hBF);
		wr(ufc_pkg::A_EFR, 8'h08);
		wr(ufc_pkg::A_LCR, 8'h03);
		wr(ufc_pkg::A_IER, 8'h00);
		slow <= 1'b1;
		rx(8'h61);
		rx(8'h62);
		rx(8'h63);
		wait_seen(4'h1);
		chk(last, 8'h13);
		rd(ufc_pkg::A_DATA, 8'h61);
		rd(ufc_pkg::A_DATA, 8'h62);
		wait_seen(4'h2);
		chk(last, 8'h11);
		rd(ufc_pkg::A_DATA, 8'h63);
		repeat (20) @(posedge clk);
		chk(seen, 4'h2);
		// Special character stored and flagged, flow control off
		wr(ufc_pkg::A_LCR, 8'hBF);
		wr(ufc_pkg::A_EFR, 8'h20);
		wr(ufc_pkg::A_LCR, 8'h03);
		wr(ufc_pkg::A_IER, 8'h20);
		rx(8'h93);
		rd(ufc_pkg::A_ISR, ufc_pkg::IS_XOFF);
		rd(ufc_pkg::A_DATA, 8'h93);
		// Double characters: Xoff1 then Xoff2, Xon1 then Xon2
		wr(ufc_pkg::A_LCR, 8'hBF);
		wr(ufc_pkg::A_EFR, 8'h03);
		wr(ufc_pkg::A_LCR, 8'h03);
		wr(ufc_pkg::A_IER, 8'h00);
		rx(8'h13);
		rx(8'h93);
		chk(sus, 1'b1);
		rx(8'h11);
		rx(8'hC3);
		chk(sus, 1'b0);
		rx(8'h13);
		rx(8'h41);
		rd(ufc_pkg::A_DATA, 8'h13);
		rd(ufc_pkg::A_DATA, 8'h41);
		// Timeout of 4 * 5 + 12 bit times
		wr(ufc_pkg::A_LCR, 8'h00);
		wr(ufc_pkg::A_IER, 8'h08);
		trig <= 5'h08;
		rx(8'h70);
		tick(30);
		rd(ufc_pkg::A_ISR, ufc_pkg::IS_NONE);
		tick(4);
		rd(ufc_pkg::A_ISR, ufc_pkg::IS_RXTO);
		rd(ufc_pkg::A_DATA, 8'h70);
		tick(40);
		rd(ufc_pkg::A_ISR, ufc_pkg::IS_NONE);
		// Handshake event reported at the lowest level, then cleared
		wr(ufc_pkg::A_IER, 8'hC0);
		@(posedge clk) hs <= 2'h1;
		@(posedge clk) hs <= 2'h0;
		rd(ufc_pkg::A_ISR, ufc_pkg::IS_HS);
		rd(ufc_pkg::A_ISR, ufc_pkg::IS_NONE);
		// Interrupt output enable
		chk(ioe, 1'b1);
		sel <= 1'b1;
		repeat (6) @(posedge clk);
		#1 chk(ioe, 1'b0);
		sel <= 1'b0;
		wr(ufc_pkg::A_MCR, 8'h08);
		repeat (6) @(posedge clk);
		#1 chk(ioe, 1'b0);
		give_verdict;
	end
endmodule // testbench
